// File: logic/dms_consts.vh
// Constants for the DSP accumulate and saturation engine
`ifndef DMS_CONSTS_VH
`define DMS_CONSTS_VH
// ****************************************
// Register byte offsets
// ****************************************
`define DMS_OFF_CTRL 8'h00
`define DMS_OFF_STATUS 8'h04
`define DMS_OFF_OPND 8'h08
`define DMS_OFF_CMD 8'h0C
`define DMS_OFF_ACCUMULATOR_A_LO 8'h10
`define DMS_OFF_ACCUMULATOR_A_HI 8'h14
`define DMS_OFF_ACCUMULATOR_B_LO 8'h18
`define DMS_OFF_ACCUMULATOR_B_HI 8'h1C
`define DMS_OFF_MULRES 8'h20
`define DMS_OFF_WBDATA 8'h24
// ****************************************
// Core control field positions
// ****************************************
`define DMS_CTL_INT 0
`define DMS_CTL_RND 1
`define DMS_CTL_SUPER 4
`define DMS_CTL_DWSAT 5
`define DMS_CTL_ACC_B_SAT_ENABLE 6
`define DMS_CTL_ACC_A_SAT_ENABLE 7
`define DMS_CTL_US 12
`define DMS_CTL_ACC_A_OVERFLOW_TRAP_ENABLE 16
`define DMS_CTL_ACC_B_OVERFLOW_TRAP_ENABLE 17
`define DMS_CTL_CATASTROPHIC_OVERFLOW_TRAP_ENABLE 18
`define DMS_CTL_MASK 32'h0007_10F3
`define DMS_CTL_RESET 32'h0000_0020
// ****************************************
// Status field positions
// ****************************************
`define DMS_ST_OA 15
`define DMS_ST_OB 14
`define DMS_ST_SA 13
`define DMS_ST_SB 12
`define DMS_ST_OAB 11
`define DMS_ST_SAB 10
// ****************************************
// Command fields and operation codes
// ****************************************
`define DMS_CMD_TGT 4
`define DMS_CMD_WORD 5
`define DMS_CMD_XUNS 6
`define DMS_CMD_YUNS 7
`define DMS_CMD_RNDEN 13
`define DMS_OP_NOP 4'h0
`define DMS_OP_CLR 4'h1
`define DMS_OP_MPY 4'h2
`define DMS_OP_MPYN 4'h3
`define DMS_OP_MAC 4'h4
`define DMS_OP_MSC 4'h5
`define DMS_OP_ED 4'h6
`define DMS_OP_EUCLIDEAN_DISTANCE_ACCUMULATE_OP 4'h7
`define DMS_OP_ADDACC 4'h8
`define DMS_OP_SUBACC 4'h9
`define DMS_OP_NEG 4'hA
`define DMS_OP_LAC 4'hB
`define DMS_OP_ADDD 4'hC
`define DMS_OP_MUL 4'hD
`define DMS_OP_SAC 4'hE
// ****************************************
// Saturation limits
// ****************************************
`define DMS_MAX40 40'h7F_FFFF_FFFF
`define DMS_MIN40 40'h80_0000_0000
`define DMS_MAX32 40'h00_7FFF_FFFF
`define DMS_MIN32 40'hFF_8000_0000
`define DMS_MAX16 16'h7FFF
`define DMS_MIN16 16'h8000
`endif

// File: logic/dms_dsp_engine.v
// DSP engine datapath: multiplier, 40-bit accumulators, saturation, APB registers
// Functional notes
// RULE1 - Unsigned operands are zero-extended into multiplier bit 16
// RULE2 - Signed operands are sign-extended into multiplier bit 16
// RULE3 - Multiplier/scaler yields 33 bits, sign-extended to 40 for the adder
// RULE4 - Scaler gives 1.31 fractional or 32-bit integer product by mode
// RULE5 - MCU multiply returns 16 bits for bytes, 32 bits for words
// RULE6 - Adder reads and writes back one selected accumulator, A or B
// RULE7 - Accumulate-add and load pass data through the barrel shifter
// RULE8 - Accumulator-to-accumulator add, subtract and negate need no operand
// RULE9 - Zero input option; add uses true data, subtract complement and borrow
// RULE10 - Guard overflow flag tracks whether bits 39:32 differ after each pass
// RULE11 - Newly set guard overflow with its enable requests arithmetic trap
// RULE12 - Saturation flags are sticky; only software clears them
// RULE13 - With saturation off, bit 39 overflow sets the saturation flag
// RULE14 - Saturation off and catastrophic enable: set flag requests trap
// RULE15 - Combined flags are OR of both guard and both saturation flags
// RULE16 - Saturation uses adder result, flags, enables and mode select
// RULE17 - Super mode clamps to 9.31 limits on bit 39 overflow, sets flag
// RULE18 - Normal mode clamps to 1.31 limits on bit 31 overflow, sets flag
// RULE19 - Normal saturation never sets guard or combined overflow flags
// RULE20 - Catastrophic mode wraps past bit 39 and flags the overflow
// RULE21 - Integer select high means integer operands, low signed fractions
// RULE22 - Conventional rounding adds bit 15 to the high word
// RULE23 - Data-write saturation clamps to 0x7FFF or 0x8000
// RULE24 - Fractional product is shifted left one bit to align 1.31
`timescale 1ns/1ps
`include "dms_consts.vh"

module dms_dsp_engine (
  input wire clk,
  input wire rst_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  output reg arith_trap_req,
  output reg either_guard_overflow,
  output reg either_saturated
);

  // ****************************************
  // Helpers
  // ****************************************
  // Widen a 16-bit operand to 17 bits, zero or sign fill
  function [16:0] ext17;
    input [15:0] v;
    input uns;
    begin
      ext17 = uns ? {1'b0, v} : {v[15], v}; // see RULE1 see RULE2
    end
  endfunction

  // X-bus data at bits 31:16; positive count shifts right, negative left
  function [39:0] bshift;
    input [15:0] d;
    input [4:0] sh;
    reg [39:0] v;
    reg [4:0] mag;
    begin
      v = {{8{d[15]}}, d, 16'h0000};
      mag = sh[4] ? (~sh + 5'h01) : sh;
      if (sh[4]) begin
        bshift = v << mag;
      end else begin
        bshift = $signed(v) >>> mag;
      end
    end
  endfunction

  // ****************************************
  // Registers
  // ****************************************
  reg [31:0] ctrl_r;
  reg [15:0] opx_r;
  reg [15:0] opy_r;
  reg [39:0] accumulator_a_r;
  reg [39:0] accumulator_b_r;
  reg ga_r;
  reg gb_r;
  reg sa_r;
  reg sb_r;
  reg [31:0] mulres_r;
  reg [15:0] wb_r;

  wire acc_a_sat_enable = ctrl_r[`DMS_CTL_ACC_A_SAT_ENABLE];
  wire acc_b_sat_enable = ctrl_r[`DMS_CTL_ACC_B_SAT_ENABLE];
  wire super_sat_select = ctrl_r[`DMS_CTL_SUPER];
  wire data_write_sat_enable = ctrl_r[`DMS_CTL_DWSAT];
  wire round_mode_select = ctrl_r[`DMS_CTL_RND];
  wire int_mode_select = ctrl_r[`DMS_CTL_INT];
  wire multiply_unsigned_select = ctrl_r[`DMS_CTL_US];

  // ****************************************
  // APB decode
  // ****************************************
  wire acc_en = psel & penable & pready;
  wire wr_en = acc_en & pwrite;
  wire wr_cmd = wr_en & (paddr == `DMS_OFF_CMD);
  wire [3:0] op = wr_cmd ? pwdata[3:0] : `DMS_OP_NOP;
  wire tgt_b = pwdata[`DMS_CMD_TGT];
  wire [4:0] shamt = pwdata[12:8];

  // ****************************************
  // Multiplier and scaler
  // ****************************************
  reg [16:0] ma;
  reg [16:0] mb;
  reg [15:0] diff;
  reg mcu_mul;
  reg dsp_uns;
  reg [33:0] prod34;
  reg [32:0] prod33;
  reg [39:0] prod40;

  // Operand select, widening and scaling
  always @* begin
    diff = opx_r - opy_r;
    mcu_mul = (op == `DMS_OP_MUL);
    // Fractional mode forces signed operands
    dsp_uns = multiply_unsigned_select & int_mode_select; // see RULE21
    if (mcu_mul) begin
      if (pwdata[`DMS_CMD_WORD]) begin
        ma = ext17(opx_r, pwdata[`DMS_CMD_XUNS]);
        mb = ext17(opy_r, pwdata[`DMS_CMD_YUNS]);
      end else begin
        ma = pwdata[`DMS_CMD_XUNS] ? {9'h000, opx_r[7:0]} : {{9{opx_r[7]}}, opx_r[7:0]};
        mb = pwdata[`DMS_CMD_YUNS] ? {9'h000, opy_r[7:0]} : {{9{opy_r[7]}}, opy_r[7:0]};
      end
    end else if (op == `DMS_OP_ED || op == `DMS_OP_EUCLIDEAN_DISTANCE_ACCUMULATE_OP) begin
      ma = ext17(diff, 1'b0);
      mb = ext17(diff, 1'b0);
    end else begin
      ma = ext17(opx_r, dsp_uns);
      mb = ext17(opy_r, dsp_uns);
    end
    prod34 = $signed(ma) * $signed(mb);
    // Fractional results realign to 1.31 by a one-bit left shift
    if (!int_mode_select && !mcu_mul) begin
      prod33 = {prod34[31:0], 1'b0}; // see RULE4 see RULE24
    end else begin
      prod33 = prod34[32:0]; // see RULE4
    end
    prod40 = {{7{prod33[32]}}, prod33}; // see RULE3
  end

  // ****************************************
  // Adder/subtracter
  // ****************************************
  reg [39:0] src;
  reg [39:0] oth;
  reg [39:0] ain;
  reg [39:0] bin;
  reg sub;
  reg zero_a;
  reg pass;
  reg [40:0] sum41;

  // Operand routing per operation
  always @* begin
    src = tgt_b ? accumulator_b_r : accumulator_a_r; // see RULE6
    oth = tgt_b ? accumulator_a_r : accumulator_b_r;
    sub = 1'b0;
    zero_a = 1'b0;
    pass = 1'b1;
    bin = 40'h00_0000_0000;
    case (op)
      `DMS_OP_CLR: begin
        zero_a = 1'b1;
      end
      `DMS_OP_MPY, `DMS_OP_ED: begin
        zero_a = 1'b1;
        bin = prod40;
      end
      `DMS_OP_MPYN: begin
        zero_a = 1'b1;
        sub = 1'b1;
        bin = prod40;
      end
      `DMS_OP_MAC, `DMS_OP_EUCLIDEAN_DISTANCE_ACCUMULATE_OP: begin
        bin = prod40;
      end
      `DMS_OP_MSC: begin
        sub = 1'b1;
        bin = prod40;
      end
      `DMS_OP_ADDACC: begin
        bin = oth; // see RULE8
      end
      `DMS_OP_SUBACC: begin
        sub = 1'b1;
        bin = oth; // see RULE8
      end
      `DMS_OP_NEG: begin
        zero_a = 1'b1;
        sub = 1'b1;
        bin = src; // see RULE8
      end
      `DMS_OP_LAC: begin
        zero_a = 1'b1;
        bin = bshift(opx_r, shamt); // see RULE7
      end
      `DMS_OP_ADDD: begin
        bin = bshift(opx_r, shamt); // see RULE7
      end
      default: begin
        pass = 1'b0;
      end
    endcase
    ain = zero_a ? 40'h00_0000_0000 : src;
    // Subtract feeds complement with carry high meaning no borrow
    if (sub) begin
      bin = ~bin; // see RULE9
    end
    sum41 = {ain[39], ain} + {bin[39], bin} + {40'h00_0000_0000, sub}; // see RULE9
  end

  // ****************************************
  // Saturation and flags
  // ****************************************
  reg sat_en;
  reg ovf39;
  reg ovf31;
  reg [39:0] res;
  reg set_sat;
  reg guard;

  // Pick result and flag effects from mode and overflow
  always @* begin
    sat_en = tgt_b ? acc_b_sat_enable : acc_a_sat_enable; // see RULE16
    ovf39 = sum41[40] ^ sum41[39];
    ovf31 = ~((&sum41[40:31]) | ~(|sum41[40:31]));
    res = sum41[39:0];
    set_sat = 1'b0;
    if (!sat_en) begin
      // Wraps freely; sign loss is only recorded
      set_sat = ovf39; // see RULE13 see RULE20
    end else if (super_sat_select) begin
      if (ovf39) begin
        res = sum41[40] ? `DMS_MIN40 : `DMS_MAX40; // see RULE17
        set_sat = 1'b1; // see RULE17
      end
    end else if (ovf31) begin
      res = sum41[40] ? `DMS_MIN32 : `DMS_MAX32; // see RULE18
      set_sat = 1'b1; // see RULE18
    end
    // Normal saturation keeps guard bits out of play
    if (sat_en && !super_sat_select) begin
      guard = 1'b0; // see RULE19
    end else begin
      // Set only while the guard bits disagree among themselves
      guard = (|res[39:32]) & ~(&res[39:32]); // see RULE10
    end
  end

  // ****************************************
  // Round and data-write saturation
  // ****************************************
  reg [39:0] wsrc;
  reg rinc;
  reg [23:0] rsum;
  reg [15:0] wdata;

  // Round the high word, then clamp to 1.15 if enabled
  always @* begin
    wsrc = tgt_b ? accumulator_b_r : accumulator_a_r;
    if (!pwdata[`DMS_CMD_RNDEN]) begin
      rinc = 1'b0;
    end else if (round_mode_select) begin
      rinc = wsrc[15]; // see RULE22
    end else if (wsrc[15:0] == 16'h8000) begin
      rinc = wsrc[16];
    end else begin
      rinc = wsrc[15];
    end
    rsum = wsrc[39:16] + {23'h00_0000, rinc}; // see RULE22
    wdata = rsum[15:0];
    if (data_write_sat_enable) begin
      // Sign comes from the source's top bit
      if (!wsrc[39] && (rsum[23] || rsum[23:15] != 9'h000)) begin
        wdata = `DMS_MAX16; // see RULE23
      end else if (wsrc[39] && (!rsum[23] || rsum[23:15] != 9'h1FF)) begin
        wdata = `DMS_MIN16; // see RULE23
      end
    end
  end

  // ****************************************
  // Next flag state
  // ****************************************
  wire st_wr = wr_en & (paddr == `DMS_OFF_STATUS);
  wire clr_sa = st_wr & (pwdata[`DMS_ST_SA] | pwdata[`DMS_ST_SAB]);
  wire clr_sb = st_wr & (pwdata[`DMS_ST_SB] | pwdata[`DMS_ST_SAB]);
  wire upd_a = pass & ~tgt_b;
  wire upd_b = pass & tgt_b;
  wire ga_nxt = upd_a ? guard : ga_r; // see RULE10
  wire gb_nxt = upd_b ? guard : gb_r; // see RULE10
  // A set in the clearing cycle survives the clear
  wire sa_nxt = (sa_r & ~clr_sa) | (upd_a & set_sat); // see RULE12
  wire sb_nxt = (sb_r & ~clr_sb) | (upd_b & set_sat); // see RULE12
  wire trap_ov = (ga_nxt & ~ga_r & ctrl_r[`DMS_CTL_ACC_A_OVERFLOW_TRAP_ENABLE])
                | (gb_nxt & ~gb_r & ctrl_r[`DMS_CTL_ACC_B_OVERFLOW_TRAP_ENABLE]); // see RULE11
  wire trap_cov = pass & ~sat_en & ctrl_r[`DMS_CTL_CATASTROPHIC_OVERFLOW_TRAP_ENABLE]
                 & (tgt_b ? sb_nxt : sa_nxt); // see RULE14

  // ****************************************
  // Register read mux
  // ****************************************
  reg [31:0] rd;
  reg rd_err;

  // Unmapped addresses read zero with an error
  always @* begin
    rd = 32'h0000_0000;
    rd_err = 1'b0;
    case (paddr)
      `DMS_OFF_CTRL: rd = ctrl_r;
      `DMS_OFF_STATUS: begin
        rd[`DMS_ST_OA] = ga_r;
        rd[`DMS_ST_OB] = gb_r;
        rd[`DMS_ST_SA] = sa_r;
        rd[`DMS_ST_SB] = sb_r;
        rd[`DMS_ST_OAB] = ga_r | gb_r; // see RULE15
        rd[`DMS_ST_SAB] = sa_r | sb_r; // see RULE15
      end
      `DMS_OFF_OPND: rd = {opy_r, opx_r};
      `DMS_OFF_CMD: rd = 32'h0000_0000;
      `DMS_OFF_ACCUMULATOR_A_LO: rd = accumulator_a_r[31:0];
      `DMS_OFF_ACCUMULATOR_A_HI: rd = {24'h00_0000, accumulator_a_r[39:32]};
      `DMS_OFF_ACCUMULATOR_B_LO: rd = accumulator_b_r[31:0];
      `DMS_OFF_ACCUMULATOR_B_HI: rd = {24'h00_0000, accumulator_b_r[39:32]};
      `DMS_OFF_MULRES: rd = mulres_r;
      `DMS_OFF_WBDATA: rd = {16'h0000, wb_r};
      default: rd_err = 1'b1;
    endcase
  end

  // ****************************************
  // APB handshake
  // ****************************************
  // One wait-free access: ready rises in the access phase
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable & ~pready;
      if (psel & ~penable) begin
        prdata <= pwrite ? 32'h0000_0000 : rd;
        pslverr <= rd_err;
      end
    end
  end

  // ****************************************
  // Engine state
  // ****************************************
  // Configuration, accumulators and results
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= `DMS_CTL_RESET;
      opx_r <= 16'h0000;
      opy_r <= 16'h0000;
      accumulator_a_r <= 40'h00_0000_0000;
      accumulator_b_r <= 40'h00_0000_0000;
      ga_r <= 1'b0;
      gb_r <= 1'b0;
      sa_r <= 1'b0;
      sb_r <= 1'b0;
      mulres_r <= 32'h0000_0000;
      wb_r <= 16'h0000;
      arith_trap_req <= 1'b0;
      either_guard_overflow <= 1'b0;
      either_saturated <= 1'b0;
    end else begin
      if (wr_en && paddr == `DMS_OFF_CTRL) begin
        ctrl_r <= pwdata & `DMS_CTL_MASK;
      end
      if (wr_en && paddr == `DMS_OFF_OPND) begin
        opx_r <= pwdata[15:0];
        opy_r <= pwdata[31:16];
      end
      if (upd_a) begin
        accumulator_a_r <= res; // see RULE6
      end
      if (upd_b) begin
        accumulator_b_r <= res; // see RULE6
      end
      if (op == `DMS_OP_MUL) begin
        // Byte result fills only the low half
        mulres_r <= pwdata[`DMS_CMD_WORD] ? prod34[31:0] : {16'h0000, prod34[15:0]}; // see RULE5
      end
      if (op == `DMS_OP_SAC) begin
        wb_r <= wdata;
      end
      ga_r <= ga_nxt;
      gb_r <= gb_nxt;
      sa_r <= sa_nxt;
      sb_r <= sb_nxt;
      arith_trap_req <= trap_ov | trap_cov; // see RULE11 see RULE14
      either_guard_overflow <= ga_nxt | gb_nxt; // see RULE15
      either_saturated <= sa_nxt | sb_nxt; // see RULE15
    end
  end

endmodule

// File: tb/dms_engine_checker.sv
// Bus and flag timing checker for the DSP engine ports
`timescale 1ns/1ps
`include "dms_consts.vh"
module dms_engine_checker (
  input wire clk,
  input wire rst_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire arith_trap_req,
  input wire either_guard_overflow,
  input wire either_saturated
);
  // ****************************************
  // Helper terms
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire acc_w = psel && penable && pready;
  wire cmd_wr = acc_w && pwrite && (paddr == `DMS_OFF_CMD);
  wire st_hit = acc_w && pwrite && (paddr == `DMS_OFF_STATUS);
  wire st_clr = st_hit && (pwdata[13] || pwdata[12] || pwdata[10]);
  wire mapped = (paddr <= `DMS_OFF_WBDATA) && (paddr[1:0] == 2'b00);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable && pready;
  endsequence
  // Zero-wait slave: answer stands exactly one cycle
  a_ready_after_setup: assert property (s_setup |=> pready) else $error("no pready");
  a_ready_one_cycle: assert property (pready |=> !pready) else $error("pready too long");
  a_err_unmapped: assert property (s_access ##0 !mapped |-> pslverr) else $error("no pslverr");
  a_err_mapped: assert property (s_access ##0 mapped |-> !pslverr) else $error("bad pslverr");
  a_write_data_zero: assert property (acc_w && pwrite |-> prdata == 32'h0) else $error("prdata");
  a_trap_cause: assert property (arith_trap_req |-> $past(cmd_wr)) else $error("trap");
  a_trap_pulse: assert property (arith_trap_req |=> !arith_trap_req) else $error("trap long");
  a_guard_cause: assert property ($changed(either_guard_overflow) |-> $past(cmd_wr))
    else $error("guard changed");
  a_sat_rise: assert property ($rose(either_saturated) |-> $past(cmd_wr))
    else $error("sat rose");
  a_sat_sticky: assert property ($fell(either_saturated) |-> $past(st_clr))
    else $error("sat fell");
endmodule

// File: tb/dms_cpu_model.sv
// APB master standing in for the instruction decode side
`timescale 1ns/1ps
module dms_cpu_model (
  input wire clk,
  input wire rst_n,
  input wire go,
  input wire wr,
  input wire [7:0] addr,
  input wire [31:0] wdata,
  output reg done,
  output reg [31:0] rdata,
  output reg err,
  output reg psel,
  output reg penable,
  output reg pwrite,
  output reg [7:0] paddr,
  output reg [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr
);
  // One transfer per request; address and data are inverted on release so stale data cannot pass
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      done <= 1'b0;
      rdata <= 32'h0;
      err <= 1'b0;
      psel <= 1'b0;
      penable <= 1'b0;
      pwrite <= 1'b0;
      paddr <= 8'h00;
      pwdata <= 32'h0;
    end else begin
      done <= 1'b0;
      if (!psel && go) begin
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wdata;
      end else if (psel && !penable) begin
        penable <= 1'b1;
      end else if (psel && pready) begin
        psel <= 1'b0;
        penable <= 1'b0;
        done <= 1'b1;
        rdata <= prdata;
        err <= pslverr;
        paddr <= ~paddr;
        pwdata <= ~pwdata;
      end
    end
  end
endmodule

// File: tb/tb_top.sv
// Self-checking bench for the DSP accumulate and saturation engine
`timescale 1ns/1ps
`include "dms_consts.vh"
module tb_top;
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  reg go = 1'b0;
  reg wr = 1'b0;
  reg [7:0] addr = 8'h00;
  reg [31:0] wdata = 32'h0;
  wire done, err, psel, penable, pwrite, pready, pslverr, trap, eg, es;
  wire [7:0] paddr;
  wire [31:0] pwdata, prdata, rdata;
  integer bad_count = 0;
  integer n_tests = 0;
  integer trap_cnt = 0;
  integer exp_traps = 0;
  integer i;
  reg [31:0] seed = 32'h7C1FFCD3;
  reg [31:0] ctrl;
  reg [31:0] lo;
  longint acc [0:1];
  reg g [0:1];
  reg s [0:1];
  dms_dsp_engine uut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .arith_trap_req(trap), .either_guard_overflow(eg),
    .either_saturated(es));
  dms_cpu_model cpu (.clk(clk), .rst_n(rst_n), .go(go), .wr(wr), .addr(addr),
    .wdata(wdata), .done(done), .rdata(rdata), .err(err), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  // ****************************************
  // Shared tasks and reference model
  // ****************************************
  initial forever #25 clk = ~clk;
  // Trap pulses last one cycle, so counting edges counts requests
  always @(posedge clk) if (trap === 1'b1) trap_cnt <= trap_cnt + 1;
  function automatic [31:0] xs(input [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  task finish_test;
    begin
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
    end
  endtask
  task chk(input string nm, input [39:0] e, input [39:0] v);
    begin
      n_tests++;
      if (v !== e) begin
        bad_count++;
        $display("mismatch %0s expected %h seen %h", nm, e, v);
      end
    end
  endtask
  task apb(input w, input [7:0] a, input [31:0] d);
    integer k;
    begin
      @(posedge clk);
      go <= 1'b1;
      wr <= w;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      go <= 1'b0;
      for (k = 0; k < 20 && done !== 1'b1; k++) begin
        @(posedge clk);
        #1;
      end
      if (done !== 1'b1) begin
        chk("apb_done", 40'h1, 40'h0);
        finish_test;
      end
    end
  endtask
  function automatic longint prod(input [15:0] x, input [15:0] y);
    if (ctrl[0] && ctrl[12]) return longint'({16'h0, x}) * longint'({16'h0, y});
    if (ctrl[0]) return longint'($signed(x)) * longint'($signed(y));
    return (longint'($signed(x)) * longint'($signed(y))) <<< 1;
  endfunction
  // One adder pass on the model, three saturation modes
  task pass(input integer t, input longint p);
    longint r;
    reg se, g_old;
    begin
      r = acc[t] + p;
      se = ctrl[7 - t];
      g_old = g[t];
      if (se && !ctrl[4]) begin
        if (r > 64'sh7FFFFFFF || r < -64'sh80000000) s[t] = 1'b1;
        if (r > 64'sh7FFFFFFF) r = 64'sh7FFFFFFF;
        if (r < -64'sh80000000) r = -64'sh80000000;
        g[t] = 1'b0;
      end else begin
        if (r > 64'sh7FFFFFFFFF || r < -64'sh8000000000) begin
          s[t] = 1'b1;
          if (se) r = (r > 0) ? 64'sh7FFFFFFFFF : -64'sh8000000000;
          else r = {{24{r[39]}}, r[39:0]};
        end
        g[t] = r[39:32] != 8'h00 && r[39:32] != 8'hFF;
      end
      acc[t] = r;
      if ((g[t] && !g_old && ctrl[16 + t]) || (!se && ctrl[18] && s[t])) exp_traps++;
    end
  endtask
  // Clear, then n operations of one kind, checking ports after each
  task run(input [31:0] c, input integer t, input [15:0] x, input [15:0] y,
    input [3:0] op, input integer n);
    integer k;
    begin
      ctrl = c;
      apb(1'b1, `DMS_OFF_CTRL, c);
      apb(1'b1, `DMS_OFF_STATUS, 32'h400);
      s[0] = 1'b0;
      s[1] = 1'b0;
      apb(1'b1, `DMS_OFF_OPND, {y, x});
      apb(1'b1, `DMS_OFF_CMD, {27'h0, t[0], `DMS_OP_CLR});
      acc[t] = 0;
      pass(t, 0);
      for (k = 0; k < n; k++) begin
        apb(1'b1, `DMS_OFF_CMD, {27'h0, t[0], op});
        if (op == `DMS_OP_MPY) acc[t] = 0;
        pass(t, (op == `DMS_OP_MSC) ? -prod(x, y) : prod(x, y));
        chk("either_guard", {39'h0, g[0] | g[1]}, {39'h0, eg});
        chk("either_sat", {39'h0, s[0] | s[1]}, {39'h0, es});
      end
      apb(1'b0, (t == 0) ? `DMS_OFF_ACCUMULATOR_A_LO : `DMS_OFF_ACCUMULATOR_B_LO, 32'h0);
      lo = rdata;
      apb(1'b0, (t == 0) ? `DMS_OFF_ACCUMULATOR_A_HI : `DMS_OFF_ACCUMULATOR_B_HI, 32'h0);
      chk("accumulator", acc[t][39:0], {rdata[7:0], lo});
      apb(1'b0, `DMS_OFF_STATUS, 32'h0);
      chk("status", {34'h0, g[0], g[1], s[0], s[1], g[0] | g[1], s[0] | s[1]},
        {34'h0, rdata[15:10]});
      chk("traps", exp_traps, trap_cnt);
    end
  endtask
  // One command, then one read compared with a hand-worked value
  task op_chk(input [31:0] c, input [7:0] a, input [31:0] e);
    begin
      apb(1'b1, `DMS_OFF_CMD, c);
      apb(1'b0, a, 32'h0);
      chk("op_result", {8'h0, e}, {8'h0, rdata});
    end
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    g[0] = 1'b0;
    g[1] = 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, `DMS_OFF_CTRL, 32'h0);
    chk("ctrl_reset", {8'h0, `DMS_CTL_RESET}, {8'h0, rdata});
    apb(1'b0, 8'h80, 32'h0);
    chk("unmapped_err", 40'h1, {39'h0, err});
    chk("unmapped_data", 40'h0, {8'h0, rdata});
    // Random products in signed, unsigned and fractional modes
    for (i = 0; i < 24; i++) begin
      seed = xs(seed);
      run((i % 3 == 0) ? 32'h1 : (i % 3 == 1) ? 32'h1001 : 32'h1000, i % 2,
        seed[15:0], seed[31:16], (i % 4 == 3) ? `DMS_OP_MSC : `DMS_OP_MPY, 1);
    end
    // Catastrophic wrap, super and normal saturation, negative clamp
    run(32'h00070001, 1, 16'h8000, 16'h8000, `DMS_OP_MAC, 520);
    run(32'h00070091, 0, 16'h8000, 16'h8000, `DMS_OP_MAC, 520);
    run(32'h00070081, 0, 16'h8000, 16'h8000, `DMS_OP_MAC, 4);
    run(32'h00000041, 1, 16'h8000, 16'h8000, `DMS_OP_MSC, 4);
    // Remaining opcodes last, since they leave flags the model does not track
    apb(1'b1, `DMS_OFF_CTRL, 32'h21);
    apb(1'b1, `DMS_OFF_OPND, 32'h0003_FFFE);
    op_chk(32'h2D, `DMS_OFF_MULRES, 32'hFFFF_FFFA);
    op_chk(32'hCD, `DMS_OFF_MULRES, 32'h0000_02FA);
    op_chk(32'h0D, `DMS_OFF_MULRES, 32'h0000_FFFA);
    op_chk(32'h06, `DMS_OFF_ACCUMULATOR_A_LO, 32'h0000_0019);
    op_chk(32'h07, `DMS_OFF_ACCUMULATOR_A_LO, 32'h0000_0032);
    op_chk(32'h041B, `DMS_OFF_ACCUMULATOR_B_LO, 32'hFFFF_E000);
    op_chk(32'h08, `DMS_OFF_ACCUMULATOR_A_LO, 32'hFFFF_E032);
    op_chk(32'h19, `DMS_OFF_ACCUMULATOR_B_LO, 32'hFFFF_FFCE);
    op_chk(32'h1A, `DMS_OFF_ACCUMULATOR_B_LO, 32'h0000_0032);
    op_chk(32'h03, `DMS_OFF_ACCUMULATOR_A_LO, 32'h0000_0006);
    op_chk(32'h1F0C, `DMS_OFF_ACCUMULATOR_A_LO, 32'hFFFC_0006);
    op_chk(32'h0E, `DMS_OFF_WBDATA, 32'h0000_FFFC);
    apb(1'b1, `DMS_OFF_OPND, 32'h0000_4000);
    op_chk(32'h1E1B, `DMS_OFF_ACCUMULATOR_B_HI, 32'h0000_0001);
    op_chk(32'h1E, `DMS_OFF_WBDATA, 32'h0000_7FFF);
    op_chk(32'h1A, `DMS_OFF_ACCUMULATOR_B_HI, 32'h0000_00FF);
    op_chk(32'h1E, `DMS_OFF_WBDATA, 32'h0000_8000);
    apb(1'b1, `DMS_OFF_OPND, 32'h0080_0100);
    op_chk(32'h02, `DMS_OFF_ACCUMULATOR_A_LO, 32'h0000_8000);
    op_chk(32'h200E, `DMS_OFF_WBDATA, 32'h0000_0000);
    apb(1'b1, `DMS_OFF_CTRL, 32'h23);
    op_chk(32'h200E, `DMS_OFF_WBDATA, 32'h0000_0001);
    finish_test;
  end
endmodule
bind dms_dsp_engine dms_engine_checker chk_i (.clk(clk), .rst_n(rst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .arith_trap_req(arith_trap_req),
  .either_guard_overflow(either_guard_overflow), .either_saturated(either_saturated));
